// ### include/mks_pkg.sv
// shared constants and types for the menu key and sync status block
package mks_pkg;
  // bus register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MENU    = 8'h04;
  localparam logic [7:0] OFS_VAL     = 8'h08;
  localparam logic [7:0] OFS_SYNC    = 8'h0C;
  // control field positions
  localparam int CTRL_RXBR_LSB = 0;
  localparam int CTRL_LEDEN    = 8;
  // status field positions
  localparam int SYNC_DONE_BIT = 0;
  localparam int SYNC_SYNCED   = 1;
  // reset values and limits
  localparam logic [4:0] RXBR_RESET = 5'h0_00A;
  localparam logic [4:0] RXBR_MAX   = 5'h0_019;
  localparam logic [7:0] NUM_MAX    = 8'h0_063;
  // debounce time and count at 40 MHz
  localparam int DEB_US     = 10;
  localparam int CLK_MHZ    = 40;
  localparam int DEB_CYCLES = DEB_US * CLK_MHZ;
  // seconds per decoded minute
  localparam logic [5:0] MINUTE_SECS = 6'h0_3C;
  // main menu positions in display order
  typedef enum logic [3:0] {M_NORMAL, M_DISPMODE, M_ALARM, M_BRIGHT, M_TSIG, M_CLOCK,
                            M_INFO, M_CHIPNO, M_FWVER} mks_main_type;
  // submenu item counts, exit is last
  localparam logic [3:0] ALARM_ITEMS  = 4'h8;
  localparam logic [3:0] BRIGHT_ITEMS = 4'hC;
  localparam logic [3:0] TSIG_ITEMS   = 4'h9;
  localparam logic [3:0] CLOCK_ITEMS  = 4'h9;
  // time signal submenu item codes
  localparam logic [3:0] TS_RXBR = 4'h1;
  localparam logic [3:0] TS_LED  = 4'h3;
  // setting classes
  typedef enum logic [1:0] {K_NUM, K_ONOFF, K_LIST, K_NONE} mks_kind_type;
  // synchronisation status
  typedef enum logic [1:0] {S_NOSIG, S_SEARCH, S_READ, S_DONE} mks_sync_type;
endpackage : mks_pkg

// ### design/mks_menu_keys.sv
// menu key navigation and sync status indication
`timescale 1ns/1ps
module mks_menu_keys
  import mks_pkg::*;
(
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, low active
  input  wire logic [3:0]  key_n,         // menu+, menu-, plus, minus pins, low active
  input  wire logic        pulse_n,       // receiver pulse pin, low active
  input  wire logic        signal_ok,     // acceptable signal seen
  input  wire logic        marker_found,  // minute marker second found
  input  wire logic        second_tick,   // one pulse per second
  input  wire logic        work_cycle,    // reception work cycle level
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic             display_on_ff, // display active
  output logic             status_dp_ff,  // single decimal point
  output logic [1:0]       banner_ff,     // 0 nosig 1 search 2 reading_banner 3 time
  output logic             rx_led_ff      // receive LED
);
  // key synchroniser, debounce and press edge
  logic [3:0]  ks1_ff, ks2_ff, kst_ff, kold_ff, press_ff;
  logic [15:0] kcnt_ff [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_key
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ks1_ff[g] <= 1'b0;
          ks2_ff[g] <= 1'b0;
          kst_ff[g] <= 1'b0;
          kcnt_ff[g] <= '0;
        end
        else
        begin
          ks1_ff[g] <= ~key_n[g];
          ks2_ff[g] <= ks1_ff[g];
          if (ks2_ff[g] == kst_ff[g])
            kcnt_ff[g] <= '0;
          else if (kcnt_ff[g] == 16'(DEB_CYCLES - 1))
          begin
            kst_ff[g] <= ks2_ff[g];
            kcnt_ff[g] <= '0;
          end
          else
            kcnt_ff[g] <= kcnt_ff[g] + 16'h0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kold_ff <= '0;
      press_ff <= '0;
    end
    else
    begin
      kold_ff <= kst_ff;
      press_ff <= kst_ff & ~kold_ff;
    end
  end
  wire fwd   = press_ff[0];
  wire back  = press_ff[1];
  wire plus  = press_ff[2];
  wire minus = press_ff[3];

  // menu state
  mks_main_type main_ff, nxt_main;
  logic       insub_ff, nxt_insub;
  logic [3:0] item_ff, nxt_item;
  logic [4:0] rxbr_ff;
  logic       leden_ff;
  logic [7:0] val_ff, nxt_val;
  logic       sw_rxbr_we;
  logic [4:0] sw_rxbr;
  logic       sw_leden;
  logic       sw_leden_we;
  wire  [3:0] sub_items = (main_ff == M_ALARM) ? ALARM_ITEMS :
                          (main_ff == M_BRIGHT) ? BRIGHT_ITEMS :
                          (main_ff == M_TSIG) ? TSIG_ITEMS : CLOCK_ITEMS;
  wire        has_sub   = (main_ff == M_ALARM) || (main_ff == M_BRIGHT) ||
                          (main_ff == M_TSIG) || (main_ff == M_CLOCK);
  wire        at_exit   = insub_ff && (item_ff == sub_items - 4'h1);
  wire        on_rxbr   = insub_ff && (main_ff == M_TSIG) && (item_ff == TS_RXBR);
  wire        on_led    = insub_ff && (main_ff == M_TSIG) && (item_ff == TS_LED);
  // setting class of the current position
  wire mks_kind_type kind = on_led ? K_ONOFF :
                            (main_ff == M_DISPMODE) ? K_LIST :
                            (insub_ff && !at_exit) ? K_NUM : K_NONE;
  logic in_menu_ff;

  // navigation next-state
  always_comb
  begin
    nxt_main  = main_ff;
    nxt_insub = insub_ff;
    nxt_item  = item_ff;
    nxt_val   = val_ff;
    if (fwd)
    begin
      if (insub_ff)
        nxt_item = (item_ff == sub_items - 4'h1) ? 4'h0 : item_ff + 4'h1;
      else if (in_menu_ff)
        nxt_main = (main_ff == M_FWVER) ? M_NORMAL : mks_main_type'(main_ff + 4'h1);
    end
    else if (back)
    begin
      if (insub_ff)
        nxt_item = (item_ff == 4'h0) ? sub_items - 4'h1 : item_ff - 4'h1;
      else if (in_menu_ff)
        nxt_main = (main_ff == M_NORMAL) ? M_FWVER : mks_main_type'(main_ff - 4'h1);
    end
    else if (plus)
    begin
      if (!insub_ff && has_sub)
      begin
        nxt_insub = 1'b1;
        nxt_item  = 4'h0;
      end
      else if (at_exit)
        nxt_insub = 1'b0;
      else if (kind == K_NUM && val_ff != NUM_MAX)
        nxt_val = val_ff + 8'h01;
      else if (kind == K_LIST)
        nxt_val = {6'h00, 2'(val_ff[1:0] + 2'h1)};
    end
    else if (minus)
    begin
      if (kind == K_NUM && val_ff != 8'h00)
        nxt_val = val_ff - 8'h01;
      else if (kind == K_LIST)
        nxt_val = {6'h00, 2'(val_ff[1:0] - 2'h1)};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_ff <= M_NORMAL;
      insub_ff <= 1'b0;
      item_ff <= '0;
      val_ff <= '0;
      in_menu_ff <= 1'b0;
    end
    else
    begin
      main_ff <= nxt_main;
      insub_ff <= nxt_insub;
      item_ff <= nxt_item;
      val_ff <= nxt_val;
      if (fwd || back)
        in_menu_ff <= 1'b1;
    end
  end

  // receive brightness setting, software write wins over keys
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rxbr_ff <= RXBR_RESET;
    else if (sw_rxbr_we)
      rxbr_ff <= (sw_rxbr > RXBR_MAX) ? RXBR_MAX : sw_rxbr;
    else if (on_rxbr && plus && rxbr_ff != RXBR_MAX)
      rxbr_ff <= rxbr_ff + 5'h01;
    else if (on_rxbr && minus && rxbr_ff != 5'h00)
      rxbr_ff <= rxbr_ff - 5'h01;
  end

  // led enable setting, own byte lane
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      leden_ff <= 1'b1;
    else if (sw_leden_we)
      leden_ff <= sw_leden;
    // on/off forced by plus and minus
    else if (on_led && plus)
      leden_ff <= 1'b1;
    else if (on_led && minus)
      leden_ff <= 1'b0;
  end

  // pulse synchroniser and falling edge
  logic p1_ff, p2_ff, p3_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
      p3_ff <= 1'b0;
    end
    else
    begin
      p1_ff <= ~pulse_n;
      p2_ff <= p1_ff;
      p3_ff <= p2_ff;
    end
  end
  wire pulse_hi   = p2_ff;
  wire pulse_rise = p2_ff & ~p3_ff;

  // sync progression
  mks_sync_type sync_ff;
  logic [5:0]   secs_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_ff <= S_NOSIG;
      secs_ff <= '0;
    end
    else
      unique case (sync_ff)
        S_NOSIG:  if (signal_ok) sync_ff <= S_SEARCH;
        S_SEARCH:
        begin
          if (!signal_ok)
            sync_ff <= S_NOSIG;
          else if (marker_found)
          begin
            sync_ff <= S_READ;
            secs_ff <= '0;
          end
        end
        S_READ:
        begin
          if (!signal_ok)
            sync_ff <= S_NOSIG;
          else if (second_tick)
          begin
            if (secs_ff == MINUTE_SECS - 6'h01)
              sync_ff <= S_DONE;
            secs_ff <= secs_ff + 6'h01;
          end
        end
        S_DONE:   sync_ff <= S_DONE;
      endcase
  end
  wire synced = (sync_ff == S_DONE);

  // display, decimal point and LED outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      display_on_ff <= 1'b1;
      status_dp_ff <= 1'b0;
      banner_ff <= 2'h0;
      rx_led_ff <= 1'b0;
    end
    else
    begin
      display_on_ff <= synced || (rxbr_ff != 5'h00);
      banner_ff <= 2'(sync_ff);
      if (synced || rxbr_ff != 5'h00)
        status_dp_ff <= 1'b0;
      else if (pulse_rise)
        status_dp_ff <= ~status_dp_ff;
      if (!synced)
        rx_led_ff <= leden_ff & (signal_ok ? pulse_hi : work_cycle);
      else
        rx_led_ff <= 1'b0;
    end
  end

  // axi-lite write path
  logic        awhave_ff, whave_ff;
  logic [7:0]  awa_ff;
  logic [31:0] wd_ff;
  logic [1:0]  wst_ff;
  wire         wdo = awhave_ff && whave_ff && !s_axi_bvalid;
  // lane 0 carries brightness, lane 1 the led enable
  assign sw_rxbr_we  = wdo && (awa_ff == OFS_CTRL) && wst_ff[0];
  assign sw_leden_we = wdo && (awa_ff == OFS_CTRL) && wst_ff[1];
  assign sw_rxbr    = wd_ff[CTRL_RXBR_LSB +: 5];
  assign sw_leden   = wd_ff[CTRL_LEDEN];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awhave_ff <= 1'b0;
      whave_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      wst_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !awhave_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !whave_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awhave_ff <= 1'b1;
        awa_ff <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        whave_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        wst_ff <= s_axi_wstrb[1:0];
      end
      if (wdo)
      begin
        awhave_ff <= 1'b0;
        whave_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_ff == OFS_CTRL) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi-lite read path
  wire [31:0] rmux = (s_axi_araddr[7:0] == OFS_CTRL) ? {23'h0, leden_ff, 3'h0, rxbr_ff} :
                     (s_axi_araddr[7:0] == OFS_MENU) ? {22'h0, in_menu_ff, insub_ff, item_ff, 4'h0} |
                                                        {28'h0, main_ff} :
                     (s_axi_araddr[7:0] == OFS_VAL)  ? {24'h0, val_ff} :
                     {28'h0, sync_ff, synced, synced};
  wire        rok  = (s_axi_araddr[7:0] == OFS_CTRL) || (s_axi_araddr[7:0] == OFS_MENU) ||
                     (s_axi_araddr[7:0] == OFS_VAL) || (s_axi_araddr[7:0] == OFS_SYNC);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rok ? rmux : 32'h0000_0000;
        s_axi_rresp <= rok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  // submenu entry by plus only
  sub_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(insub_ff) |-> $past(plus)) else $error("submenu entered without plus");
  sub_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (insub_ff && fwd && at_exit) |=> item_ff == 4'h0) else $error("submenu did not wrap");
  main_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_menu_ff && !insub_ff && fwd && main_ff == M_NORMAL) |=> main_ff == M_DISPMODE)
    else $error("forward step wrong");
  main_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_menu_ff && !insub_ff && back && main_ff == M_NORMAL) |=> main_ff == M_FWVER)
    else $error("backward step wrong");
  rxbr_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rxbr_ff <= RXBR_MAX) else $error("receive brightness out of range");
  disp_blank_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rxbr_ff == 5'h00 && !synced) |=> !display_on_ff) else $error("display not blanked");
  disp_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rxbr_ff != 5'h00) |=> display_on_ff) else $error("display not active");
  sync_search_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync_ff == S_NOSIG && signal_ok) |=> sync_ff == S_SEARCH ##1 banner_ff == 2'h1)
    else $error("search text missing");
  led_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !leden_ff |=> !rx_led_ff) else $error("led lit while disabled");
  led_on_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (on_led && plus && !sw_leden_we) |=> leden_ff) else $error("on/off not set");
endmodule : mks_menu_keys

// ### sim/mks_far_side.sv
// far side model: push buttons and time signal receiver
`timescale 1ns/1ps
module mks_far_side
(
  input  wire logic       aclk,    // system clock
  output logic      [3:0] key_n,   // buttons, low while pressed
  output logic            pulse_n  // receiver output, low active
);
  // keys rest released, receiver idles high
  initial
  begin
    key_n   = 4'hf;
    pulse_n = 1'b1;
  end

  // bouncing press, held for hold cycles, then a long release
  task automatic press(input int k, input int hold);
    repeat (2)
    begin
      @(posedge aclk) key_n[k] <= 1'b0;
      @(posedge aclk) key_n[k] <= 1'b1;
    end
    @(posedge aclk) key_n[k] <= 1'b0;
    repeat (hold) @(posedge aclk);
    key_n[k] <= 1'b1;
    repeat (460) @(posedge aclk);
  endtask : press

  task automatic pulse(input int len);
    @(posedge aclk) pulse_n <= 1'b0;
    repeat (len) @(posedge aclk);
    pulse_n <= 1'b1;
    repeat (len) @(posedge aclk);
  endtask : pulse
endmodule : mks_far_side

// ### sim/tb.sv
// self-checking bench for the menu key and sync status block
`timescale 1ns/1ps
module tb
  import mks_pkg::*;
;
  logic        aclk, aresetn, signal_ok, marker_found, second_tick, work_cycle, pulse_n;
  logic [3:0]  key_n, wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, banner, resp;
  logic        disp, dp, led, b;
  int          errors, tests_run, cyc, seed, pos, item, insub, inmenu, rxbr, leden, k, n;

  mks_far_side far (.aclk(aclk), .key_n(key_n), .pulse_n(pulse_n));

  mks_menu_keys DUT (.aclk(aclk), .aresetn(aresetn), .key_n(key_n), .pulse_n(pulse_n),
    .signal_ok(signal_ok), .marker_found(marker_found), .second_tick(second_tick),
    .work_cycle(work_cycle), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .display_on_ff(disp), .status_dp_ff(dp),
    .banner_ff(banner), .rx_led_ff(led));

  // clock, 25 ns period
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bus write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge aclk);
    awaddr  <= 32'(a);
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      aw = aw | (awvalid & awready);
      w  = w | (wvalid & wready);
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask : axw

  // bus read
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr  <= 32'(a);
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    v    = rdata;
    resp = rresp;
  endtask : axr

  // control write, mirrored into the model
  task automatic ctrl(input logic [31:0] v, input logic [3:0] s);
    axw(OFS_CTRL, v, s);
    if (s[0]) rxbr = v[4:0] > 25 ? 25 : v[4:0];
    if (s[1]) leden = v[8];
  endtask : ctrl

  function automatic int cnt(input int p);
    return p == 2 ? 8 : p == 3 ? 12 : (p == 4 || p == 5) ? 9 : 0;
  endfunction : cnt

  // compare menu position and settings against the model
  task automatic check_model();
    logic [31:0] v;
    axr(OFS_MENU, v);
    if (!insub) v[7:4] = 4'h0;
    chk("menu", v[9:0], (inmenu << 9) | (insub << 8) | ((insub ? item : 0) << 4) | pos);
    axr(OFS_CTRL, v);
    chk("ctrl", v[8:0], (leden << 8) | rxbr);
  endtask : check_model

  // one key press and the model's reaction
  task automatic key(input int kk);
    int c;
    far.press(kk, 450);
    c = cnt(pos);
    case (kk)
      0: if (!inmenu) inmenu = 1; else if (insub) item = (item + 1) % c; else pos = (pos + 1) % 9;
      1: if (!inmenu) inmenu = 1; else if (insub) item = (item + c - 1) % c; else pos = (pos + 8) % 9;
      2:
      begin
        if (insub && item == c - 1) insub = 0;
        else if (insub && pos == 4 && item == 1) rxbr = rxbr < 25 ? rxbr + 1 : 25;
        else if (insub && pos == 4 && item == 3) leden = 1;
        else if (!insub && inmenu && c > 0)
        begin
          insub = 1;
          item  = 0;
        end
      end
      default:
      begin
        if (insub && pos == 4 && item == 1 && rxbr > 0) rxbr--;
        else if (insub && pos == 4 && item == 3) leden = 0;
      end
    endcase
    check_model();
  endtask : key

  function automatic logic [1:0] sig(input int s);
    return s == 0 ? 2'(disp) : s == 1 ? 2'(dp) : s == 2 ? 2'(led) : banner;
  endfunction : sig

  // bounded wait for an output to settle, then compare
  task automatic wait_for(input string nm, input int s, input logic [1:0] e);
    int i;
    for (i = 0; i < 40 && sig(s) !== e; i++) @(posedge aclk);
    chk(nm, sig(s), e);
  endtask : wait_for

  task automatic tick();
    @(posedge aclk) second_tick <= 1'b1;
    @(posedge aclk) second_tick <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : tick

  // main sequence
  initial
  begin
    {aresetn, signal_ok, marker_found, second_tick, work_cycle} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr, wstrb} = '0;
    {errors, tests_run, cyc, pos, item, insub, inmenu} = '0;
    seed  = 31;
    rxbr  = 10;
    leden = 1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check_model();
    axr(8'h10, d);
    chk("unmapped_rd", {d[29:0], resp}, 32'h0000_0002);
    axw(8'h14, 32'h0000_0000, 4'hf);
    chk("unmapped_wr", resp, 32'h0000_0002);
    // main menu walk wrapping both ways, then alarm submenu wrap and exit
    for (k = 0; k < 10; k++) key(0);
    for (k = 0; k < 7; k++) key(1);
    key(2);
    for (k = 0; k < 8; k++) key(0);
    key(1);
    key(2);
    // short random glitch must do nothing
    k = $random(seed) & 1;
    n = ($random(seed) & 255) + 1;
    far.press(k, n);
    check_model();
    // display mode list steps back with wrap, then forward
    key(1);
    key(3);
    axr(OFS_VAL, d);
    chk("list_back", d, 32'h0000_0003);
    key(2);
    axr(OFS_VAL, d);
    chk("list_fwd", d, 32'h0000_0000);
    key(0);
    // time-signal submenu: numeric and on/off settings
    key(0);
    key(0);
    key(2);
    key(0);
    key(3);
    key(2);
    ctrl(32'h0000_011f, 4'hf);
    key(2);
    key(3);
    key(0);
    key(0);
    key(3);
    key(3);
    key(2);
    ctrl(32'h0000_0005, 4'h1);
    check_model();
    // led in work cycle while unsynchronised
    work_cycle <= 1'b1;
    wait_for("led_work", 2, 2'h1);
    work_cycle <= 1'b0;
    wait_for("led_work_off", 2, 2'h0);
    ctrl(32'h0000_0005, 4'h3);
    work_cycle <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("led_disabled", led, 1'b0);
    ctrl(32'h0000_0105, 4'h3);
    wait_for("disp_on", 0, 2'h1);
    signal_ok <= 1'b1;
    wait_for("banner_search", 3, 2'h1);
    fork
      far.pulse(80);
      wait_for("led_pulse", 2, 2'h1);
    join
    wait_for("led_idle", 2, 2'h0);
    // blank display, decimal point follows pulses
    ctrl(32'h0000_0100, 4'h3);
    wait_for("disp_off", 0, 2'h0);
    for (k = 0; k < 2; k++)
    begin
      b = dp;
      far.pulse(40);
      wait_for("dp_toggle", 1, {1'b0, ~b});
    end
    // marker, then one full minute to the time
    @(posedge aclk) marker_found <= 1'b1;
    @(posedge aclk) marker_found <= 1'b0;
    wait_for("banner_read", 3, 2'h2);
    for (k = 0; k < 59; k++) tick();
    chk("banner_59", banner, 2'h2);
    tick();
    wait_for("banner_time", 3, 2'h3);
    axr(OFS_SYNC, d);
    chk("sync_state", d[3:1], 3'h7);
    // mid-run reset brings back the start settings
    @(posedge aclk);
    aresetn   <= 1'b0;
    signal_ok <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    {pos, item, insub, inmenu} = '0;
    rxbr  = 10;
    leden = 1;
    check_model();
    chk("banner_reset", banner, 2'h0);
    chk("disp_reset", disp, 1'b1);
    print_verdict();
  end
endmodule : tb
